// ---- logic/move_multiply_negate_exec.sv ----
/*
 * Execution datapath for the accumulator and peripheral copies, the two unsigned
 * multiplies and the accumulator negate, sequenced over four quarter phases.
 * Assumes a data memory whose read data answers combinationally to the read address in
 * the same cycle, and which stores the write data at the clock edge that ends a write cycle.
 */
// How it works
// [RULE1] Peripheral copy moves a byte from addresses 0..31 to any of 256 locations.
// [RULE2] Accumulator copy writes the working register to any location, flags untouched, one cycle.
// [RULE3] Literal multiply forms unsigned working register times literal into the product pair.
// [RULE4] Literal multiply keeps the working register; multiplies never touch any flag.
// [RULE5] File multiply forms working register times data byte into the product pair.
// [RULE6] File multiply leaves both the working register and the data location unchanged.
// [RULE7] A zero product is not reported on the zero flag or elsewhere.
// [RULE8] A build parameter removes both multiply instructions.
// [RULE9] Negate forms inverted plus one and updates wrap, carry, half carry, zero.
// [RULE10] Negate select 0 writes working register and location; select 1 only location.
// [RULE11] Decode in Q1, read in Q2, compute in Q3, write in Q4.
`timescale 1ns/1ps
`default_nettype none
`include "mmn_exec_params.svh"

module move_multiply_negate_exec
   import mmn_exec_pkg::*;
#(
   parameter bit MULTIPLIER_PRESENT = 1'b1,
   parameter logic [7:0] WORKING_REG_ADDR = `MMN_WORKING_REG_ADDR_DEFAULT
) (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic [15:0] INSTR_I,
   input wire logic INSTR_VALID_I,
   output logic Q1_O,
   output logic MEM_RD_EN_O,
   output logic [7:0] MEM_RD_ADDR_O,
   input wire logic [7:0] MEM_RD_DATA_I,
   output logic MEM_WR_EN_O,
   output logic [7:0] MEM_WR_ADDR_O,
   output logic [7:0] MEM_WR_DATA_O,
   output logic [7:0] WORKING_REGISTER_O,
   output logic [7:0] PRODUCT_HIGH_BYTE_O,
   output logic [7:0] PRODUCT_LOW_BYTE_O,
   output flags_s FLAGS_O
);

   state_s st_r;
   state_s st_nxt;

   function automatic op_e decode_op(input logic [15:0] instr);
      op_e op;
      op = OP_NONE;
      if ((instr & `MMN_MASK_8_HIGH) == `MMN_OPC_COPY_ACC) begin
         op = OP_COPY_ACCUMULATOR;
      end else if ((instr & `MMN_MASK_3_HIGH) == `MMN_OPC_COPY_PERIPH) begin
         op = OP_COPY_PERIPHERAL;
      end else if ((instr & `MMN_MASK_7_HIGH) == `MMN_OPC_NEGATE) begin
         op = OP_NEGATE_ACCUMULATOR;
      end else if (MULTIPLIER_PRESENT && (instr & `MMN_MASK_8_HIGH) == `MMN_OPC_MUL_LITERAL) begin
         op = OP_MULTIPLY_LITERAL; // RULE8
      end else if (MULTIPLIER_PRESENT && (instr & `MMN_MASK_8_HIGH) == `MMN_OPC_MUL_FILE) begin
         op = OP_MULTIPLY_FILE; // RULE8
      end
      return op;
   endfunction : decode_op

   // The working register is visible in the data space at one address, both for reads and writes.
   function automatic logic is_working_addr(input logic [7:0] addr);
      return addr == WORKING_REG_ADDR;
   endfunction : is_working_addr

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_en = 1'b0;
      st_nxt.wr_en = 1'b0;
      unique case (st_r.phase)
         PHASE_Q1: begin
            st_nxt.phase = PHASE_Q2;
            st_nxt.op = INSTR_VALID_I ? decode_op(INSTR_I) : OP_NONE; // RULE11
            st_nxt.file_addr = INSTR_I[`MMN_FILE_MSB:`MMN_FILE_LSB];
            st_nxt.periph_addr = {`MMN_PERIPH_PAD, INSTR_I[`MMN_PERIPH_MSB:`MMN_PERIPH_LSB]}; // RULE1
            st_nxt.select_bit = INSTR_I[`MMN_SELECT_BIT];
            st_nxt.literal = INSTR_I[`MMN_FILE_MSB:`MMN_FILE_LSB];
            if (INSTR_VALID_I && decode_op(INSTR_I) != OP_NONE
                && decode_op(INSTR_I) != OP_MULTIPLY_LITERAL) begin
               st_nxt.rd_en = 1'b1; // RULE11
            end
            if (decode_op(INSTR_I) == OP_COPY_PERIPHERAL) begin
               st_nxt.rd_addr = st_nxt.periph_addr; // RULE1
            end else begin
               st_nxt.rd_addr = INSTR_I[`MMN_FILE_MSB:`MMN_FILE_LSB];
            end
         end
         PHASE_Q2: begin
            st_nxt.phase = PHASE_Q3;
            if (st_r.op == OP_MULTIPLY_LITERAL) begin
               st_nxt.operand = st_r.literal; // RULE3
            end else if (is_working_addr(st_r.rd_addr)) begin
               st_nxt.operand = st_r.working_register;
            end else begin
               st_nxt.operand = MEM_RD_DATA_I; // RULE11
            end
         end
         PHASE_Q3: begin
            st_nxt.phase = PHASE_Q4;
            st_nxt.product = `MMN_WORD_ZERO;
            st_nxt.flags_new = st_r.flags;
            st_nxt.result = st_r.operand;
            unique case (st_r.op)
               OP_COPY_PERIPHERAL: begin
                  st_nxt.result = st_r.operand; // RULE1
                  st_nxt.flags_new.zero_flag = st_r.operand == `MMN_BYTE_ZERO;
                  st_nxt.wr_en = 1'b1;
               end
               OP_COPY_ACCUMULATOR: begin
                  st_nxt.result = st_r.working_register; // RULE2
                  st_nxt.wr_en = 1'b1;
               end
               OP_MULTIPLY_LITERAL,
               OP_MULTIPLY_FILE: begin
                  st_nxt.product = 16'(st_r.working_register * st_r.operand); // RULE3 RULE5
               end
               OP_NEGATE_ACCUMULATOR: begin
                  st_nxt.result = 8'(~st_r.working_register + `MMN_BYTE_ONE); // RULE9
                  st_nxt.flags_new.carry_flag = st_r.working_register == `MMN_BYTE_ZERO; // RULE9
                  st_nxt.flags_new.half_carry_flag = st_r.working_register[3:0] == `MMN_NIBBLE_ZERO; // RULE9
                  st_nxt.flags_new.signed_wrap_flag = st_r.working_register == `MMN_SIGN_ONLY; // RULE9
                  st_nxt.flags_new.zero_flag = st_r.working_register == `MMN_BYTE_ZERO; // RULE9
                  st_nxt.wr_en = 1'b1;
               end
               default: begin
               end
            endcase
         end
         PHASE_Q4: begin
            st_nxt.phase = PHASE_Q1;
            unique case (st_r.op)
               OP_COPY_PERIPHERAL: begin
                  st_nxt.flags = st_r.flags_new;
                  if (is_working_addr(st_r.file_addr)) begin
                     st_nxt.working_register = st_r.result;
                  end
               end
               OP_COPY_ACCUMULATOR: begin
               end
               OP_MULTIPLY_LITERAL,
               OP_MULTIPLY_FILE: begin
                  st_nxt.product_high_byte = st_r.product[15:8]; // RULE3 RULE5
                  st_nxt.product_low_byte = st_r.product[7:0]; // RULE3 RULE4 RULE5 RULE6 RULE7
               end
               OP_NEGATE_ACCUMULATOR: begin
                  st_nxt.flags = st_r.flags_new; // RULE9
                  if (!st_r.select_bit || is_working_addr(st_r.file_addr)) begin
                     st_nxt.working_register = st_r.result; // RULE10
                  end
               end
               default: begin
               end
            endcase
            st_nxt.op = OP_NONE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign Q1_O = st_r.phase == PHASE_Q1;
   assign MEM_RD_EN_O = st_r.rd_en;
   assign MEM_RD_ADDR_O = st_r.rd_addr;
   assign MEM_WR_EN_O = st_r.wr_en && !is_working_addr(st_r.file_addr); // RULE11
   assign MEM_WR_ADDR_O = st_r.file_addr;
   assign MEM_WR_DATA_O = st_r.result;
   assign WORKING_REGISTER_O = st_r.working_register;
   assign PRODUCT_HIGH_BYTE_O = st_r.product_high_byte;
   assign PRODUCT_LOW_BYTE_O = st_r.product_low_byte;
   assign FLAGS_O = st_r.flags;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   logic is_mul_q4;
   logic is_neg_q4;
   assign is_mul_q4 = st_r.phase == PHASE_Q4
                      && (st_r.op == OP_MULTIPLY_LITERAL || st_r.op == OP_MULTIPLY_FILE);
   assign is_neg_q4 = st_r.phase == PHASE_Q4 && st_r.op == OP_NEGATE_ACCUMULATOR;

   sequence seq_q2_to_q1;
      st_r.phase == PHASE_Q2 ##1 st_r.phase == PHASE_Q3 ##1 st_r.phase == PHASE_Q4 ##1 st_r.phase == PHASE_Q1;
   endsequence

   a_phase_order_walk: assert property (st_r.phase == PHASE_Q1 |=> seq_q2_to_q1) // RULE11
      else $error("quarter phases left their order");

   a_read_in_q2: assert property (st_r.rd_en |-> st_r.phase == PHASE_Q2) // RULE11
      else $error("data read outside the second quarter");

   a_write_in_q4: assert property (st_r.wr_en |-> st_r.phase == PHASE_Q4) // RULE11
      else $error("data write outside the fourth quarter");

   a_periph_low_addr: assert property (st_r.rd_en && st_r.op == OP_COPY_PERIPHERAL // RULE1
                                       |-> st_r.rd_addr[7:5] == 3'h0)
      else $error("peripheral copy read above address 31");

   a_copy_acc_data: assert property (st_r.phase == PHASE_Q4 && st_r.op == OP_COPY_ACCUMULATOR // RULE2
                                     |-> st_r.wr_en && MEM_WR_DATA_O == WORKING_REGISTER_O ##1 $stable(FLAGS_O))
      else $error("accumulator copy wrote wrong data or changed flags");

   a_mul_product_pair: assert property (is_mul_q4 // RULE3
                                        |=> {PRODUCT_HIGH_BYTE_O, PRODUCT_LOW_BYTE_O}
                                            == 16'($past(st_r.working_register) * $past(st_r.operand)))
      else $error("product pair does not match the operands");

   a_mul_keeps_state: assert property (is_mul_q4 |=> $stable(WORKING_REGISTER_O) && $stable(FLAGS_O)) // RULE4
      else $error("multiply disturbed the working register or the flags");

   a_mulfile_no_write: assert property (st_r.op == OP_MULTIPLY_FILE |-> !st_r.wr_en) // RULE6
      else $error("file multiply wrote its source location");

   a_zero_product_silent: assert property (is_mul_q4 && st_r.product == 16'h0000 // RULE7
                                           |=> $stable(FLAGS_O.zero_flag))
      else $error("zero product reached the zero flag");

   a_negate_value: assert property (is_neg_q4 |-> MEM_WR_DATA_O == 8'(8'h00 - WORKING_REGISTER_O)) // RULE9
      else $error("negate result is not the two's complement");

   a_negate_flags: assert property (is_neg_q4 // RULE9
                                    |=> FLAGS_O.zero_flag == ($past(st_r.result) == 8'h00)
                                    && FLAGS_O.carry_flag == ($past(st_r.working_register) == 8'h00)
                                    && FLAGS_O.half_carry_flag == (($past(st_r.working_register) & 8'h0f) == 8'h00)
                                    && FLAGS_O.signed_wrap_flag == ($past(st_r.working_register) == 8'h80))
      else $error("negate flags do not follow the working register");

   a_negate_dest_sel: assert property (is_neg_q4 && !st_r.select_bit // RULE10
                                       |=> WORKING_REGISTER_O == $past(st_r.result))
      else $error("negate with select 0 missed the working register");

   a_negate_only_file: assert property (is_neg_q4 && st_r.select_bit && !is_working_addr(st_r.file_addr) // RULE10
                                        |=> $stable(WORKING_REGISTER_O))
      else $error("negate with select 1 changed the working register");

   generate
      if (!MULTIPLIER_PRESENT) begin : g_no_mul
         a_mul_absent: assert property (st_r.op != OP_MULTIPLY_LITERAL && st_r.op != OP_MULTIPLY_FILE) // RULE8
            else $error("multiply decoded in a build without multiplier");
      end
   endgenerate

endmodule : move_multiply_negate_exec

`default_nettype wire

// ---- logic/mmn_exec_params.svh ----
/*
 * Constants of the move, multiply and negate execution datapath: opcode patterns,
 * instruction field positions, fixed compare and padding values and the default location of the working register.
 * Assumes it is included by its bare name from the datapath module and its bench.
 */
`ifndef MMN_EXEC_PARAMS_SVH
`define MMN_EXEC_PARAMS_SVH

`define MMN_MASK_8_HIGH 16'hff00
`define MMN_MASK_7_HIGH 16'hfe00
`define MMN_MASK_3_HIGH 16'he000

`define MMN_OPC_COPY_ACC 16'h0100
`define MMN_OPC_COPY_PERIPH 16'h4000
`define MMN_OPC_MUL_LITERAL 16'hbc00
`define MMN_OPC_MUL_FILE 16'h3400
`define MMN_OPC_NEGATE 16'h2c00

`define MMN_FILE_LSB 0
`define MMN_FILE_MSB 7
`define MMN_PERIPH_LSB 8
`define MMN_PERIPH_MSB 12
`define MMN_SELECT_BIT 8

`define MMN_BYTE_ZERO 8'h00
`define MMN_BYTE_ONE 8'h01
`define MMN_NIBBLE_ZERO 4'h0
`define MMN_WORD_ZERO 16'h0000
`define MMN_SIGN_ONLY 8'h80
`define MMN_PERIPH_PAD 3'h0

// Data address at which the working register itself is seen; the value is arbitrary.
`define MMN_WORKING_REG_ADDR_DEFAULT 8'h0f

`endif

// ---- logic/mmn_exec_pkg.sv ----
/*
 * Types shared by the move, multiply and negate execution datapath.
 * Assumes the constants header is on the include path.
 */
`default_nettype none

package mmn_exec_pkg;
   typedef enum logic [1:0] {
      PHASE_Q1 = 2'b00,
      PHASE_Q2 = 2'b01,
      PHASE_Q3 = 2'b10,
      PHASE_Q4 = 2'b11
   } phase_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_COPY_ACCUMULATOR = 3'b001,
      OP_COPY_PERIPHERAL = 3'b010,
      OP_MULTIPLY_LITERAL = 3'b011,
      OP_MULTIPLY_FILE = 3'b100,
      OP_NEGATE_ACCUMULATOR = 3'b101
   } op_e;

   typedef struct packed {
      logic signed_wrap_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } flags_s;

   typedef struct packed {
      phase_e phase;
      op_e op;
      logic [7:0] file_addr;
      logic [7:0] periph_addr;
      logic select_bit;
      logic [7:0] literal;
      logic [7:0] operand;
      logic [15:0] product;
      logic [7:0] result;
      flags_s flags_new;
      logic rd_en;
      logic [7:0] rd_addr;
      logic wr_en;
      logic [7:0] working_register;
      logic [7:0] product_high_byte;
      logic [7:0] product_low_byte;
      flags_s flags;
   } state_s;
endpackage : mmn_exec_pkg

`default_nettype wire

// ---- sim/move_multiply_negate_exec_tb.sv ----
/*
 * Self-checking bench for the move, multiply and negate execution datapath.
 * Assumes the package and the constants header are compiled and on the include path, and
 * plays the data memory itself, answering reads combinationally from its own byte array.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mmn_exec_params.svh"

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module move_multiply_negate_exec_tb
   import mmn_exec_pkg::*;
;
   localparam logic [7:0] working_register_addr = `MMN_WORKING_REG_ADDR_DEFAULT;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic instr_valid = 1'b0;
   logic q1, rd_en, wr_en;
   logic [7:0] rd_addr, wr_addr, wr_data, w, ph, pl, n_w, n_ph, n_pl;
   flags_s flags;
   wire logic [7:0] rd_data;
   logic [7:0] mem [256];
   logic [7:0] w_m, ph_m, pl_m;
   flags_s fl_m;
   int error_cnt = 0;
   int checks = 0;

   always #2 clk = ~clk;

   // An idle read port shows the inverse so that a stale value cannot pass for data.
   assign rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];

   move_multiply_negate_exec #(.MULTIPLIER_PRESENT(1'b1), .WORKING_REG_ADDR(working_register_addr)) i_dut (
      .CLK_I(clk), .RESET_N_I(rst_n), .INSTR_I(instr), .INSTR_VALID_I(instr_valid), .Q1_O(q1),
      .MEM_RD_EN_O(rd_en), .MEM_RD_ADDR_O(rd_addr), .MEM_RD_DATA_I(rd_data), .MEM_WR_EN_O(wr_en),
      .MEM_WR_ADDR_O(wr_addr), .MEM_WR_DATA_O(wr_data), .WORKING_REGISTER_O(w),
      .PRODUCT_HIGH_BYTE_O(ph), .PRODUCT_LOW_BYTE_O(pl), .FLAGS_O(flags));

   // Reduced variant without the multiplier sees the same instruction stream.
   move_multiply_negate_exec #(.MULTIPLIER_PRESENT(1'b0), .WORKING_REG_ADDR(working_register_addr)) i_dut_nomul (
      .CLK_I(clk), .RESET_N_I(rst_n), .INSTR_I(instr), .INSTR_VALID_I(instr_valid), .Q1_O(),
      .MEM_RD_EN_O(), .MEM_RD_ADDR_O(), .MEM_RD_DATA_I(rd_data), .MEM_WR_EN_O(),
      .MEM_WR_ADDR_O(), .MEM_WR_DATA_O(), .WORKING_REGISTER_O(n_w),
      .PRODUCT_HIGH_BYTE_O(n_ph), .PRODUCT_LOW_BYTE_O(n_pl), .FLAGS_O());

   task automatic summarize();
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // Issues one instruction in the coming Q1 cycle and judges its four phases.
   // The architectural state left by the previous instruction is judged in this Q1 cycle.
   // Outside Q1 the inverted word stands on the bus, which the block must ignore.
   task automatic exec(input logic [15:0] ins, input logic vld = 1'b1);
      logic [7:0] a, d, r;
      logic rd, wr, tow, chk;
      a = (ins[15:13] == 3'h2) ? {3'h0, ins[12:8]} : ins[7:0];
      d = (a == working_register_addr) ? w_m : mem[a];
      r = d;
      rd = 1'b1;
      wr = 1'b0;
      tow = 1'b0;
      chk = 1'b1;
      @(posedge clk);
      rst_n <= 1'b1;
      instr <= ins;
      instr_valid <= vld;
      @(negedge clk);
      `CHK("phase", 1'b1, q1)
      `CHK("working", w_m, w)
      `CHK("product", {ph_m, pl_m}, {ph, pl})
      `CHK("flags", fl_m, flags)
      `CHK("nomul", {w_m, 16'h0000}, {n_w, n_ph, n_pl})
      if (!vld) begin
         rd = 1'b0;
      end else if (ins[15:8] == 8'h01) begin
         wr = 1'b1;
         r = w_m;
      end else if (ins[15:13] == 3'h2) begin
         wr = 1'b1;
         fl_m.zero_flag = (d == 8'h00);
      end else if (ins[15:8] == 8'hbc) begin
         rd = 1'b0;
         {ph_m, pl_m} = w_m * ins[7:0];
      end else if (ins[15:8] == 8'h34) begin
         {ph_m, pl_m} = w_m * d;
      end else if (ins[15:9] == 7'h16) begin
         r = ~w_m + 8'h01;
         wr = 1'b1;
         tow = ~ins[8];
         fl_m = '{w_m == 8'h80, r == 8'h00, w_m[3:0] == 4'h0, w_m == 8'h00};
      end else chk = 1'b0;
      // A target equal to the working register lands in the register, not on the port.
      if (wr && ins[7:0] == working_register_addr) begin
         wr = 1'b0;
         tow = 1'b1;
      end
      @(posedge clk);
      instr <= ~ins;
      @(negedge clk);
      if (chk) `CHK("rd_en", rd, rd_en)
      if (chk && rd) `CHK("rd_addr", a, rd_addr)
      @(negedge clk);
      `CHK("quiet", 2'b00, {rd_en, wr_en})
      @(negedge clk);
      if (chk) `CHK("wr_en", wr, wr_en)
      if (wr) `CHK("wr_word", {ins[7:0], r}, {wr_addr, wr_data})
      if (wr) mem[ins[7:0]] = r;
      if (tow) w_m = r;
   endtask : exec

   task automatic load_w(input logic [7:0] v);
      mem[8'h05] = v;
      exec(16'h450f);
   endtask : load_w

   task automatic t_reset();
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("rst_state", {1'b1, 2'b00, 24'h000000, 4'h0}, {q1, rd_en, wr_en, w, ph, pl, flags})
   endtask : t_reset

   task automatic t_copy();
      load_w(8'h4f);
      mem[8'h1f] = 8'h00;
      exec(16'h5fff);
      exec(16'h0180);
   endtask : t_copy

   task automatic t_mul_lit();
      load_w(8'he2);
      exec(16'hbcc4);
      exec(16'hbc00);
   endtask : t_mul_lit

   task automatic t_mul_file();
      load_w(8'hc4);
      mem[8'h40] = 8'hb5;
      exec(16'h3440);
      exec(16'h340f);
   endtask : t_mul_file

   task automatic t_negate();
      load_w(8'h3a);
      exec(16'h2c20);
      exec(16'h2d21);
      exec(16'h2d0f);
      exec(16'h2c20, 1'b0);
      load_w(8'h80);
      exec(16'h2d22);
      mem[8'h06] = 8'h00;
      exec(16'h460f);
      exec(16'h2c23);
   endtask : t_negate

   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i);
      w_m = 8'h00;
      ph_m = 8'h00;
      pl_m = 8'h00;
      fl_m = '0;
      t_reset();
      t_copy();
      t_mul_lit();
      t_mul_file();
      t_negate();
      exec(16'h0000);
      summarize();
   end

   // Cuts a hang short; the whole sequence needs well under a thousand cycles.
   initial begin
      #40000;
      error_cnt++;
      summarize();
   end
endmodule : move_multiply_negate_exec_tb

`default_nettype wire
